// File: design/flash_pin_pkg.sv
// Shared constants and types for the serial flash pin front end.
package flash_pin_pkg;

  // Lane width modes of the current phase.
  typedef enum logic [1:0] {
    LANES_ONE,
    LANES_TWO,
    LANES_FOUR
  } lane_mode_t;

  // Number of data lanes on the pins.
  localparam int unsigned LANE_COUNT = 4;

  // Core clock period and hardware reset low time.
  localparam int unsigned CLOCK_PERIOD_NS = 40;
  localparam int unsigned RESET_LOW_NS    = 1000;
  // Least time rounds up to whole cycles.
  localparam int unsigned RESET_LOW_CYCLES =
    (RESET_LOW_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned RESET_CNT_W = $clog2(RESET_LOW_CYCLES + 1);

  // Byte width of the shift registers.
  localparam int unsigned BYTE_W = 8;

  // Field positions of the protect bus.
  localparam int unsigned PROT_SRP0 = 0;
  localparam int unsigned PROT_SRP1 = 1;

  // Reset values.
  localparam logic [7:0] BYTE_RESET = 8'h00;

endpackage : flash_pin_pkg

// File: design/link_bus_if.sv
// Signals passed between the core and the link-side shift engine.
`timescale 1ns/1ps
interface link_bus_if;
  import flash_pin_pkg::*;

  logic [7:0] rx_byte;
  logic       rx_toggle;
  logic [7:0] tx_byte;
  logic       tx_toggle;
  logic       tx_ack_toggle;
  logic [1:0] mode;
  logic       drive_en;
  logic       frame_active;

  modport core (
    input  rx_byte,
    input  rx_toggle,
    output tx_byte,
    output tx_toggle,
    input  tx_ack_toggle,
    output mode,
    output drive_en,
    input  frame_active
  );

  modport link (
    output rx_byte,
    output rx_toggle,
    input  tx_byte,
    input  tx_toggle,
    output tx_ack_toggle,
    input  mode,
    input  drive_en,
    output frame_active
  );
endinterface : link_bus_if

// File: design/link_shifter.sv
// Link-side shift engine running on the serial clock.
`timescale 1ns/1ps
module link_shifter
  import flash_pin_pkg::*;
(
  // Link clock and frame.
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       rst,
  input  wire logic       paused,
  // Lane inputs.
  input  wire logic [3:0] lane_in,
  // Lane outputs.
  output logic      [3:0] lane_out,
  // Core side.
  link_bus_if.link        bus
);

  logic [7:0] rx_sr_q;
  logic [7:0] rx_next;
  logic [7:0] rx_hold_q;
  logic [3:0] rx_cnt_q;
  logic [7:0] tx_sr_q;
  logic [3:0] tx_cnt_q;
  logic       tx_seen_q;
  logic       rx_tog_q;
  logic       ack_q;

  // Bits taken per edge in each mode.
  function automatic logic [3:0] step(input logic [1:0] m);
    if (m == 2'(LANES_FOUR)) begin
      step = 4'h4;
    end else if (m == 2'(LANES_TWO)) begin
      step = 4'h2;
    end else begin
      step = 4'h1;
    end
  endfunction : step

  // Next shift register value for the current lane width.
  always_comb begin
    rx_next = {rx_sr_q[6:0], lane_in[0]};
    if (bus.mode == 2'(LANES_FOUR)) begin
      rx_next = {rx_sr_q[3:0], lane_in};
    end else if (bus.mode == 2'(LANES_TWO)) begin
      rx_next = {rx_sr_q[5:0], lane_in[1:0]};
    end
  end

  // Completed bytes are held and flagged by a toggle that survives a
  // deselect, so raising select can never fake a byte event.
  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_hold_q <= 8'h00;
      rx_tog_q  <= 1'b0;
    end else if (!cs_n && !paused &&
                 rx_cnt_q + step(bus.mode) >= 4'h8) begin
      rx_hold_q <= rx_next;
      rx_tog_q  <= ~rx_tog_q;
    end
  end

  // Sample on rising edges; a new frame starts a fresh byte.
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx_sr_q  <= 8'h00;
      rx_cnt_q <= 4'h0;
    end else if (!paused) begin
      rx_sr_q <= rx_next;
      if (rx_cnt_q + step(bus.mode) >= 4'h8) begin
        rx_cnt_q <= 4'h0;
      end else begin
        rx_cnt_q <= rx_cnt_q + step(bus.mode);
      end
    end
  end

  // Request and acknowledge toggles persist across frames.
  always_ff @(negedge sclk or posedge rst) begin
    if (rst) begin
      tx_seen_q <= 1'b0;
      ack_q     <= 1'b0;
    end else if (!cs_n && !paused && tx_cnt_q == 4'h0 &&
                 tx_seen_q != bus.tx_toggle) begin
      tx_seen_q <= bus.tx_toggle;
      ack_q     <= bus.tx_toggle;
    end
  end

  // Shift out on falling edges; the toggle is a request from the core.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_sr_q   <= 8'h00;
      tx_cnt_q  <= 4'h0;
    end else if (!paused) begin
      if (tx_cnt_q == 4'h0 && tx_seen_q != bus.tx_toggle) begin
        tx_sr_q   <= bus.tx_byte;
        tx_cnt_q  <= 4'h8;
      end else if (tx_cnt_q != 4'h0) begin
        if (bus.mode == 2'(LANES_FOUR)) begin
          tx_sr_q <= {tx_sr_q[3:0], 4'h0};
        end else if (bus.mode == 2'(LANES_TWO)) begin
          tx_sr_q <= {tx_sr_q[5:0], 2'h0};
        end else begin
          tx_sr_q <= {tx_sr_q[6:0], 1'b0};
        end
        tx_cnt_q <= (tx_cnt_q > step(bus.mode)) ?
                    tx_cnt_q - step(bus.mode) : 4'h0;
      end
    end
  end

  // Present the high bits of the shift register on the active lanes.
  always_comb begin
    lane_out = 4'h0;
    if (bus.mode == 2'(LANES_FOUR)) begin
      lane_out = tx_sr_q[7:4];
    end else if (bus.mode == 2'(LANES_TWO)) begin
      lane_out = {2'b00, tx_sr_q[7:6]};
    end else begin
      lane_out = {2'b00, tx_sr_q[7], 1'b0}; // on lane1.
    end
  end

  assign bus.rx_byte       = rx_hold_q;
  assign bus.rx_toggle     = rx_tog_q;
  assign bus.tx_ack_toggle = ack_q;
  assign bus.frame_active  = ~cs_n;

endmodule : link_shifter

// File: design/flash_pin_front.sv
// Pin-level front end of a serial flash memory.
`timescale 1ns/1ps
module flash_pin_front
  import flash_pin_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RESET_LOW_CYCLES
)(
  // Core clock and reset.
  input  wire logic       CLOCK,
  input  wire logic       RST,
  // Serial link pins.
  input  wire logic       SCLK,
  input  wire logic       CS_N,
  input  wire logic [3:0] LANE_IN,
  output logic      [3:0] LANE_OUT,
  output logic      [3:0] LANE_OE,
  // Dedicated reset pin, pulled up so a float reads inactive.
  input  wire logic       RESET_PIN_N,
  // Configuration from the status register.
  input  wire logic       QUAD_ENABLE_BIT,
  input  wire logic       LANE3_IS_RESET,
  input  wire logic [1:0] STATUS_PROTECT_BITS,
  input  wire logic [5:0] BLOCK_PROTECT,
  // Phase control from the instruction logic.
  input  wire logic [1:0] LANE_MODE,
  input  wire logic       OUTPUT_PHASE,
  input  wire logic [7:0] TX_BYTE,
  input  wire logic       TX_LOAD,
  input  wire logic       STATUS_WRITE_REQ,
  input  wire logic       INTERNAL_BUSY,
  // Results to the instruction logic.
  output logic [7:0]      RX_BYTE,
  output logic            RX_VALID,
  output logic            TX_TAKEN,
  output logic            SELECTED,
  output logic            ARMED,
  output logic            PAUSED,
  output logic            STATUS_WRITE_OK,
  output logic            STATUS_WRITE_BLOCKED,
  output logic            HW_RESET,
  output logic            BUSY_HOLD,
  output logic [5:0]      PROTECT_REGION
);

  localparam int unsigned RCW = $clog2(RESET_CYCLES + 1);

  // Carrier between the core and the link engine.
  link_bus_if bus ();

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers into the core clock.

  logic [1:0] cs_sync_q;
  logic [1:0] rst_sync_q;
  logic [1:0] l3_sync_q;
  logic [1:0] wp_sync_q;
  logic [1:0] rx_tog_sync_q;
  logic [1:0] ack_sync_q;

  // Two flops on the select, reset, lane3 and lane2 pins and on both link toggles.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      cs_sync_q     <= 2'b11;
      rst_sync_q    <= 2'b11;
      l3_sync_q     <= 2'b11;
      wp_sync_q     <= 2'b11;
      rx_tog_sync_q <= 2'b00;
      ack_sync_q    <= 2'b00;
    end else begin
      cs_sync_q     <= {cs_sync_q[0], CS_N};
      rst_sync_q    <= {rst_sync_q[0], RESET_PIN_N};
      l3_sync_q     <= {l3_sync_q[0], LANE_IN[3]};
      wp_sync_q     <= {wp_sync_q[0], LANE_IN[2]};
      rx_tog_sync_q <= {rx_tog_sync_q[0], bus.rx_toggle};
      ack_sync_q    <= {ack_sync_q[0], bus.tx_ack_toggle};
    end
  end

  wire cs_n_s  = cs_sync_q[1];
  wire rst_n_s = rst_sync_q[1];
  wire l3_s    = l3_sync_q[1];
  wire wp_n_s  = wp_sync_q[1];

  //////////////////////////////////////////////////////////////////////////
  // Hardware reset: dedicated pin always, shared lane3 when so chosen.

  logic [RCW-1:0] rst_cnt_q;
  logic           hw_reset_q;
  logic           shared_rst_n;

  // Shared pin acts as reset only with quad enable clear.
  assign shared_rst_n = QUAD_ENABLE_BIT | ~LANE3_IS_RESET | l3_s;

  // Count a held-low reset; no configuration bit gates the dedicated pin.
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      rst_cnt_q  <= '0;
      hw_reset_q <= 1'b0;
    end else if (rst_n_s && shared_rst_n) begin
      rst_cnt_q  <= '0;
      hw_reset_q <= 1'b0;
    end else if (rst_cnt_q >= RCW'(RESET_CYCLES - 1)) begin
      hw_reset_q <= 1'b1;
    end else begin
      rst_cnt_q <= rst_cnt_q + 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Select tracking and power-up arming.

  logic cs_prev_q;
  logic armed_q;

  // Instructions are ignored until a high-to-low select edge.
  always_ff @(posedge CLOCK) begin
    if (RST || hw_reset_q) begin
      cs_prev_q <= 1'b0;
      armed_q   <= 1'b0;
    end else begin
      cs_prev_q <= cs_n_s;
      if (cs_prev_q && !cs_n_s) begin
        armed_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Pause, timed on the serial clock and crossed into the core.

  logic pause_link_q;
  logic [1:0] pause_sync_q;
  logic pause_req;

  // Pause only with quad enable clear and the pin in pause role.
  assign pause_req = ~LANE_IN[3] & ~QUAD_ENABLE_BIT & ~LANE3_IS_RESET
                   & (LANE_MODE != 2'(LANES_FOUR));

  // Pause edges take effect at a low clock: the falling edge, or
  // immediately if the clock already rests low. Mode 3 idles high so
  // the next falling edge applies.
  always_ff @(negedge SCLK or posedge CS_N) begin
    if (CS_N) begin
      pause_link_q <= 1'b0; // a deselect clears the falling-edge pause flop.
    end else begin
      pause_link_q <= pause_req;
    end
  end

  wire paused_now = pause_link_q | (pause_req & ~SCLK);

  always_ff @(posedge CLOCK) begin
    if (RST) begin
      pause_sync_q <= 2'b00;
    end else begin
      pause_sync_q <= {pause_sync_q[0], paused_now};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Link engine and byte exchange.

  logic [3:0] link_lanes;
  logic       link_rst_q;

  // Registered reset for the link engine, so no combinational glitch
  // ever reaches its asynchronous reset.
  always_ff @(posedge CLOCK) begin
    link_rst_q <= RST | hw_reset_q;
  end
  logic       tx_tog_q;
  logic       rx_seen_q;
  logic       ack_seen_q;

  link_shifter u_shift (
    .sclk     (SCLK),
    .cs_n     (CS_N),
    .rst      (link_rst_q),
    .paused   (paused_now),
    .lane_in  (LANE_IN),
    .lane_out (link_lanes),
    .bus      (bus.link)
  );

  // Quad lanes only exist with quad enable set.
  assign bus.mode     = (LANE_MODE == 2'(LANES_FOUR) && !QUAD_ENABLE_BIT)
                        ? 2'(LANES_ONE) : LANE_MODE;
  assign bus.drive_en = OUTPUT_PHASE;
  assign bus.tx_byte  = TX_BYTE;
  assign bus.tx_toggle = tx_tog_q;

  // Byte handshake; the toggle crossing carries each event once.
  always_ff @(posedge CLOCK) begin
    if (RST || hw_reset_q) begin
      tx_tog_q   <= 1'b0;
      rx_seen_q  <= 1'b0;
      ack_seen_q <= 1'b0;
      RX_BYTE    <= BYTE_RESET;
      RX_VALID   <= 1'b0;
      TX_TAKEN   <= 1'b0;
    end else begin
      RX_VALID <= 1'b0;
      TX_TAKEN <= 1'b0;
      if (TX_LOAD) begin
        tx_tog_q <= ~tx_tog_q;
      end
      if (rx_seen_q != rx_tog_sync_q[1]) begin
        rx_seen_q <= rx_tog_sync_q[1];
        RX_BYTE   <= bus.rx_byte;
        RX_VALID  <= armed_q;
      end
      if (ack_seen_q != ack_sync_q[1]) begin
        ack_seen_q <= ack_sync_q[1];
        TX_TAKEN   <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Lane drivers.

  // Float everything when deselected, paused or in hardware reset.
  always_comb begin
    LANE_OE  = 4'h0;
    LANE_OUT = link_lanes;
    if (!CS_N && !paused_now && OUTPUT_PHASE && !hw_reset_q) begin
      if (bus.mode == 2'(LANES_FOUR)) begin
        LANE_OE = 4'hF;
      end else if (bus.mode == 2'(LANES_TWO)) begin
        LANE_OE = 4'h3;
      end else begin
        LANE_OE = 4'h2;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Status, protection and busy outputs.

  logic busy_q;

  // Internal cycles keep running across deselect, cut only by reset.
  always_ff @(posedge CLOCK) begin
    if (RST || hw_reset_q) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= INTERNAL_BUSY;
    end
  end

  // Write protect counts only without quad enable.
  wire wp_active = ~QUAD_ENABLE_BIT & ~wp_n_s
                 & STATUS_PROTECT_BITS[PROT_SRP0]
                 & ~STATUS_PROTECT_BITS[PROT_SRP1];
  wire sr_locked = STATUS_PROTECT_BITS[PROT_SRP1] | wp_active;

  always_ff @(posedge CLOCK) begin
    if (RST || hw_reset_q) begin
      SELECTED             <= 1'b0;
      ARMED                <= 1'b0;
      PAUSED               <= 1'b0;
      STATUS_WRITE_OK      <= 1'b0;
      STATUS_WRITE_BLOCKED <= 1'b0;
      BUSY_HOLD            <= 1'b0;
      PROTECT_REGION       <= 6'h00;
    end else begin
      SELECTED             <= ~cs_n_s & armed_q;
      ARMED                <= armed_q;
      PAUSED               <= pause_sync_q[1];
      STATUS_WRITE_OK      <= STATUS_WRITE_REQ & ~sr_locked;
      STATUS_WRITE_BLOCKED <= STATUS_WRITE_REQ & sr_locked;
      BUSY_HOLD            <= busy_q;
      PROTECT_REGION       <= sr_locked ? BLOCK_PROTECT : 6'h00;
    end
  end

  // Reset indication, straight from its flop.
  assign HW_RESET = hw_reset_q;

endmodule : flash_pin_front

// File: testbench/flash_pin_properties.sv
// Concurrent checks on the ports of the serial flash pin front end.
`timescale 1ns/1ps
module flash_pin_checker
  import flash_pin_pkg::*;
#(
  parameter int unsigned RESET_CYCLES = RESET_LOW_CYCLES
)(
  // Core clock and reset.
  input wire logic       CLOCK,
  input wire logic       RST,
  // Pins and configuration.
  input wire logic       CS_N,
  input wire logic [3:0] LANE_IN,
  input wire logic [3:0] LANE_OE,
  input wire logic       RESET_PIN_N,
  input wire logic       QUAD_ENABLE_BIT,
  input wire logic       LANE3_IS_RESET,
  input wire logic [1:0] STATUS_PROTECT_BITS,
  input wire logic [1:0] LANE_MODE,
  input wire logic       OUTPUT_PHASE,
  input wire logic       STATUS_WRITE_REQ,
  input wire logic       INTERNAL_BUSY,
  // Results.
  input wire logic       RX_VALID,
  input wire logic       SELECTED,
  input wire logic       ARMED,
  input wire logic       PAUSED,
  input wire logic       STATUS_WRITE_OK,
  input wire logic       STATUS_WRITE_BLOCKED,
  input wire logic       HW_RESET,
  input wire logic       BUSY_HOLD
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////////////////
  // Cycles with a reset request present; saturates so it never wraps.
  logic [5:0] low_cnt_q;
  logic       rst_req;
  assign rst_req = !RESET_PIN_N ||
                   (!QUAD_ENABLE_BIT && LANE3_IS_RESET && !LANE_IN[3]);
  always_ff @(posedge CLOCK) begin
    if (RST || !rst_req) low_cnt_q <= 6'h00;
    else if (low_cnt_q != 6'h3F) low_cnt_q <= low_cnt_q + 6'h01;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Steady select, steady deselect with an internal cycle running, and steady quad enable.
  sequence sel_low; !CS_N [*5]; endsequence
  sequence busy_away; (CS_N && INTERNAL_BUSY && !HW_RESET) [*4]; endsequence
  sequence quad_on; QUAD_ENABLE_BIT [*5]; endsequence

  AST_DESELECT_FLOAT: assert property (CS_N |-> LANE_OE == 4'h0)
    else $error("lanes driven while deselected");
  AST_SELECT_SEEN: assert property (sel_low |-> SELECTED)
    else $error("select not seen");
  AST_BUSY_KEPT: assert property (busy_away |-> BUSY_HOLD)
    else $error("internal cycle dropped on deselect");
  AST_ARMED_FIRST: assert property (RX_VALID |-> ARMED)
    else $error("byte accepted before first select");
  AST_UPPER_LANES: assert property (|LANE_OE[3:2] |->
    QUAD_ENABLE_BIT && LANE_MODE == 2'h2 && OUTPUT_PHASE)
    else $error("upper lanes driven outside quad output");
  AST_WP_BLOCKS: assert property (STATUS_WRITE_REQ && !LANE_IN[2] &&
    !QUAD_ENABLE_BIT && STATUS_PROTECT_BITS == 2'h1
    |-> ##[1:3] STATUS_WRITE_BLOCKED)
    else $error("protected status write not blocked");
  AST_QE_DROPS_WP: assert property (STATUS_WRITE_REQ &&
    QUAD_ENABLE_BIT && !STATUS_PROTECT_BITS[1] |-> ##[1:3] STATUS_WRITE_OK)
    else $error("write protect active with quad enable");
  AST_ONE_ANSWER: assert property (!(STATUS_WRITE_OK &&
    STATUS_WRITE_BLOCKED)) else $error("status write both ok and blocked");
  AST_NO_PAUSE_QUAD: assert property (quad_on |-> !PAUSED)
    else $error("pause with quad enable set");
  AST_HW_RESET_LEN: assert property ($rose(HW_RESET) |->
    low_cnt_q >= RESET_CYCLES) else $error("hardware reset too early");
  AST_HW_RESET_ACT: assert property (low_cnt_q == RESET_CYCLES + 6
    |-> HW_RESET) else $error("hardware reset not taken");
endmodule : flash_pin_checker

// File: testbench/spi_ctrl_model.sv
// Behavioural bus controller driving the serial link pins.
`timescale 1ns/1ps
module spi_ctrl_model (
  // Link outputs.
  output logic            sclk,
  output logic            cs_n,
  output logic      [3:0] lane_in,
  // Device lanes.
  input  wire logic [3:0] lane_out,
  input  wire logic [3:0] lane_oe
);
  logic [3:0] cval;
  logic [3:0] coe;

  ////////////////////////////////////////////////////////////////////////////
  // Lanes carry pull-ups, so a released line reads high, never stale.
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_in[i] = lane_oe[i] ? lane_out[i] : (coe[i] ? cval[i] : 1'b1);
    end
  end

  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    cval = 4'h0;
    coe  = 4'h0;
  end

  // Clock set to cpol before the select falls and left high after it rises; 0 or 3 only.
  task automatic open_frame(input logic cpol);
    sclk = cpol;
    #20 cs_n = 1'b0;
    #20;
  endtask : open_frame

  task automatic close_frame();
    #20 cs_n = 1'b1;
    #20 sclk = 1'b1;
  endtask : close_frame

  // One byte, MSB first, w lanes per edge; rd releases the lanes.
  task automatic shift_byte(input int w, input logic rd,
                            input logic [7:0] d, output logic [7:0] q);
    logic [3:0] m;
    m = 4'((5'h01 << w) - 5'h01);
    q = 8'h00;
    for (int k = 0; k < 8 / w; k++) begin
      sclk = 1'b0;
      if (!rd) begin
        coe  = coe | m;
        cval = (cval & ~m) | ((d[7:4] >> (4 - w)) & m);
      end
      #6 sclk = 1'b1;
      q = (q << w) | (w == 1 ? {7'h00, lane_in[1]} : {4'h0, lane_in & m});
      d = d << w;
      #6;
    end
    coe = coe & ~m;
  endtask : shift_byte
endmodule : spi_ctrl_model

// File: testbench/tb_serial_flash_pin_interface.sv
// Self-checking bench for the serial flash pin front end.
`timescale 1ns/1ps
module tb_serial_flash_pin_interface;
  import flash_pin_pkg::*;
  localparam int unsigned RST_CYC = 3; // Short count keeps the run brief.
  logic       CLOCK, RST, SCLK, CS_N, RESET_PIN_N, QUAD_ENABLE_BIT;
  logic       LANE3_IS_RESET, OUTPUT_PHASE, TX_LOAD, STATUS_WRITE_REQ;
  logic       INTERNAL_BUSY, RX_VALID, TX_TAKEN, SELECTED, ARMED, PAUSED;
  logic       STATUS_WRITE_OK, STATUS_WRITE_BLOCKED, HW_RESET, BUSY_HOLD;
  logic [3:0] LANE_IN, LANE_OUT, LANE_OE;
  logic [1:0] STATUS_PROTECT_BITS, LANE_MODE;
  logic [5:0] BLOCK_PROTECT, PROTECT_REGION;
  logic [7:0] TX_BYTE, RX_BYTE, q;
  logic [4:0] tbl [5] = '{5'b00011, 5'b10010, 5'b01010, 5'b00000, 5'b10101};
  int         n_fail, n_checks, n_rx, cyc;

  flash_pin_front #(.RESET_CYCLES(RST_CYC)) uut (.*);
  spi_ctrl_model m (.sclk(SCLK), .cs_n(CS_N), .lane_in(LANE_IN),
                    .lane_out(LANE_OUT), .lane_oe(LANE_OE));

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 1'b0;
    forever #20 CLOCK = ~CLOCK;
  end

  // Byte counter and hang guard; 20000 cycles is far above the plan.
  always @(posedge CLOCK) begin
    cyc++;
    if (RX_VALID === 1'b1) n_rx++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic ticks(input int n);
    repeat (n) @(posedge CLOCK);
    #1;
  endtask : ticks

  // Waits a bounded time for the next received byte.
  task automatic write_byte(input int w, input logic cpol, input logic [7:0] d);
    int n0;
    n0 = n_rx;
    m.open_frame(cpol);
    m.shift_byte(w, 1'b0, d, q);
    m.close_frame();
    for (int i = 0; i < 20 && n_rx == n0; i++) ticks(1);
    check(RX_BYTE, d);
  endtask : write_byte

  task automatic read_byte(input int w, input logic [7:0] d);
    @(posedge CLOCK);
    TX_BYTE      <= d;
    TX_LOAD      <= 1'b1;
    OUTPUT_PHASE <= 1'b1;
    @(posedge CLOCK);
    TX_LOAD <= 1'b0;
    ticks(4);
    m.open_frame(1'b1);
    m.shift_byte(w, 1'b1, 8'h00, q);
    m.close_frame();
    @(posedge CLOCK);
    OUTPUT_PHASE <= 1'b0;
    check(q, d);
  endtask : read_byte

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {RST, RESET_PIN_N, QUAD_ENABLE_BIT, LANE3_IS_RESET} = 4'b1100;
    {OUTPUT_PHASE, TX_LOAD, STATUS_WRITE_REQ, INTERNAL_BUSY} = 4'h0;
    {STATUS_PROTECT_BITS, LANE_MODE, TX_BYTE} = 12'h000;
    BLOCK_PROTECT = 6'h2A;
    ticks(12);
    RST <= 1'b0;
    ticks(3);
    check({4'h0, LANE_OE}, 8'h00);
    m.shift_byte(1, 1'b0, 8'hE7, q);
    ticks(15);
    check(8'(n_rx), 8'h00);
    QUAD_ENABLE_BIT <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      LANE_MODE <= 2'(i);
      ticks(4);
      write_byte(1 << i, i != 0, 8'hA5 ^ 8'(i));
      read_byte(1 << i, 8'h3C + 8'(i));
    end
    // Status write gate: {wp, qe, protect bits, blocked} per row.
    m.coe[2] = 1'b1;
    foreach (tbl[i]) begin
      m.cval[2] = tbl[i][4];
      QUAD_ENABLE_BIT     <= tbl[i][3];
      STATUS_PROTECT_BITS <= tbl[i][2:1];
      ticks(4);
      STATUS_WRITE_REQ <= 1'b1;
      @(posedge CLOCK);
      STATUS_WRITE_REQ <= 1'b0;
      #1;
      for (int k = 0; k < 5 && !(STATUS_WRITE_OK | STATUS_WRITE_BLOCKED); k++)
        ticks(1);
      check({STATUS_WRITE_OK, STATUS_WRITE_BLOCKED},
            {~tbl[i][0], tbl[i][0]});
    end
    m.coe[2] = 1'b0;
    INTERNAL_BUSY <= 1'b1;
    ticks(6);
    check(BUSY_HOLD, 1'b1);
    INTERNAL_BUSY <= 1'b0;
    // Pause with the clock low, release it, then send a byte in a new frame.
    QUAD_ENABLE_BIT <= 1'b0;
    LANE_MODE       <= 2'h0;
    ticks(6);
    m.open_frame(1'b0);
    m.coe[3]  = 1'b1;
    m.cval[3] = 1'b0;
    ticks(8);
    check({PAUSED, LANE_OE}, 8'h10);
    m.cval[3] = 1'b1;
    ticks(8);
    check(PAUSED, 1'b0);
    m.coe[3] = 1'b0;
    m.close_frame();
    write_byte(1, 1'b0, 8'h69);
    RESET_PIN_N <= 1'b0;
    ticks(RST_CYC + 8);
    check(HW_RESET, 1'b1);
    RESET_PIN_N <= 1'b1;
    ticks(8);
    check(HW_RESET, 1'b0);
    write_byte(1, 1'b1, 8'h96);
    tally_and_finish();
  end
endmodule : tb_serial_flash_pin_interface

bind flash_pin_front flash_pin_checker #(.RESET_CYCLES(RESET_CYCLES)) chk (.*);
